// >>> bench/sgc_global_ctrl_assertions.sv
// Checker for the global control register slice
`timescale 1ns/1ps
module sgc_global_ctrl_assertions (
  input wire ref_clk_in,
  input wire reset_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire port5_switch_mac_interface_10m_out,
  input wire null_vid_replace_out,
  input wire [10:0] storm_threshold_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////
  // First edge after release belongs to the strap, so skip it
  sequence wr6;
    reg_wr_in && reg_addr_in == 8'h06 && !$past(reset_in);
  endsequence
  a_speed_write: assert property (wr6 |=> port5_switch_mac_interface_10m_out == $past(reg_wdata_in[4]))
    else $error("speed bit not written");
  a_nullvid_write: assert property (wr6 |=> null_vid_replace_out == $past(reg_wdata_in[3]))
    else $error("null vid bit not written");
  a_thr_high: assert property (wr6 |=> storm_threshold_out[10:8] == $past(reg_wdata_in[2:0]))
    else $error("threshold high bits not written");
  a_thr_low: assert property (reg_wr_in && reg_addr_in == 8'h07 |=> storm_threshold_out[7:0] == $past(reg_wdata_in))
    else $error("threshold low byte not written");
  a_low_readback: assert property (reg_addr_in == 8'h07 |-> reg_rdata_out == storm_threshold_out[7:0])
    else $error("low byte readback differs");
  a_thr_reset: assert property ($fell(reset_in) |-> storm_threshold_out == 11'h04a)
    else $error("threshold reset value wrong");
  a_test_zero: assert property (reg_addr_in == 8'h08 || reg_addr_in == 8'h0a |-> reg_rdata_out == 8'h00)
    else $error("factory test register not zero");
  a_test_b: assert property (reg_addr_in == 8'h09 |-> reg_rdata_out == 8'h4c)
    else $error("factory test register b wrong");
  a_rsvd_zero: assert property (reg_addr_in == 8'h0b |-> !reg_rdata_out[7])
    else $error("reserved bit reads one");
  c_wr6: cover property (wr6);
  c_read_b: cover property (reg_addr_in == 8'h09);
  c_release: cover property ($fell(reset_in));
endmodule

// >>> bench/sgc_global_ctrl_bench.sv
// Self-checking bench for the global control register slice
`timescale 1ns/1ps
module sgc_global_ctrl_bench;
  reg ref_clk_in = 0, reset_in = 1, strap = 0, wr = 0;
  reg [7:0] addr = 8'h00, wdata = 8'h00;
  reg [4:0] sof = 5'h00, blk = 5'h00;
  wire [7:0] rdata;
  wire spd, nvid;
  wire [10:0] thr;
  wire [4:0] drop;
  integer mismatches = 0, checks_done = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  // Short periods keep the run brief
  sgc_global_ctrl #(.PERIOD_100_CYC(20), .PERIOD_10_CYC(200)) u_dut (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .speed_strap_pin_in(strap), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .port5_switch_mac_interface_10m_out(spd), .null_vid_replace_out(nvid),
    .storm_threshold_out(thr), .bcast_sof_in(sof), .bcast_block_in(blk), .bcast_drop_out(drop));
  ////////////////////////////////////////////////////////////////
  task chk(input [8*6-1:0] nm, input [10:0] e, input [10:0] g);
    checks_done = checks_done + 1;
    if (e !== g) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task wreg(input [7:0] a, input [7:0] d);
    tick(1);
    addr = a;
    wdata = d;
    wr = 1;
    tick(1);
    wr = 0;
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    tick(1);
    addr = a;
    #1 chk("rdata", {3'h0, e}, {3'h0, rdata});
  endtask
  task rst;
    reset_in = 1;
    tick(6);
    reset_in = 0;
    tick(2);
  endtask
  // Frame with one block, then a second frame start on port 0
  task burst;
    tick(1);
    sof = 5'h01;
    blk = 5'h01;
    tick(1);
    sof = 5'h00;
    blk = 5'h00;
    tick(1);
    sof = 5'h01;
    tick(1);
    sof = 5'h00;
    tick(1);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #50000;
    mismatches = mismatches + 1;
    complete_run;
  end
  initial begin
    rst;
    chk("speed", 11'h000, {10'h000, spd});
    chk("thr", 11'h04a, thr);
    rchk(8'h07, 8'h4a);
    $display("reset test done");
    wreg(8'h06, 8'h1f);
    wreg(8'h07, 8'hff);
    chk("flags", 11'h003, {9'h000, spd, nvid});
    chk("thr", 11'h7ff, thr);
    rchk(8'h06, 8'h1f);
    // Test offsets are never written and the reserved bit is written as zero
    wreg(8'h0b, 8'h7f);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h4c);
    rchk(8'h0a, 8'h00);
    rchk(8'h0b, 8'h7f);
    rchk(8'h20, 8'h00);
    $display("register test done");
    strap = 1;
    rst;
    chk("speed", 11'h001, {10'h000, spd});
    $display("strap test done");
    strap = 0;
    wreg(8'h06, 8'h00);
    wreg(8'h07, 8'h01);
    burst;
    // Align to a period boundary by waiting for the drop to clear
    repeat (25) if (drop[0] === 1'b1) tick(1);
    burst;
    chk("drop", 11'h001, {6'h00, drop});
    tick(8);
    chk("drop", 11'h001, {6'h00, drop});
    tick(12);
    chk("drop", 11'h000, {6'h00, drop});
    $display("storm test done");
    complete_run;
  end
endmodule
bind sgc_global_ctrl sgc_global_ctrl_assertions u_chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .port5_switch_mac_interface_10m_out(port5_switch_mac_interface_10m_out),
  .null_vid_replace_out(null_vid_replace_out), .storm_threshold_out(storm_threshold_out));

// >>> verilog/sgc_global_ctrl.v
// Global control registers 0x06 to 0x0b with broadcast storm limiting
//
// Summary of operation
// R1 - Bit 4 of offset 0x06 selects the fifth-port MAC speed, 1 for 10Mbps and 0 for 100Mbps.
// R2 - The speed bit is loaded from the speed strap pin at reset, pull-down giving 100Mbps by default.
// R3 - Bit 3 of offset 0x06 enables replacing a null VLAN identifier with the 12-bit port identifier.
// R4 - The 11-bit storm threshold takes bits 10:8 from 0x06 bits 2:0 and bits 7:0 from 0x07, in 64-byte blocks.
// R5 - The measurement period is 50 ms at 100 megabit and 500 ms at 10 megabit.
// R6 - The threshold resets to 000 in the upper bits and 0x4a in the low byte.
// R7 - Offsets 0x08, 0x09 and 0x0a are read-only and read 0x00, 0x4c and 0x00.
// R8 - Bit 7 of offset 0x0b is reserved, read-only and reads 0.
// R9 - Broadcast blocks are counted per port each period and further broadcast frames are dropped at the threshold.
`timescale 1ns/1ps
`include "sgc_regs.vh"
module sgc_global_ctrl #(
  parameter NUM_PORTS = 5,
  parameter PERIOD_100_CYC = (`SGC_CLK_HZ / 1000) * `SGC_PERIOD_100_MS,
  parameter PERIOD_10_CYC = (`SGC_CLK_HZ / 1000) * `SGC_PERIOD_10_MS
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // Strap pin
  input wire speed_strap_pin_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  // Frame steering
  output wire port5_switch_mac_interface_10m_out,
  output wire null_vid_replace_out,
  output wire [10:0] storm_threshold_out,
  // Per-port broadcast traffic
  input wire [NUM_PORTS-1:0] bcast_sof_in,
  input wire [NUM_PORTS-1:0] bcast_block_in,
  output wire [NUM_PORTS-1:0] bcast_drop_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Local constants
  localparam CNT_W = 11;
  localparam PER_W = 32;
  localparam [PER_W-1:0] PER_100_LEN = PERIOD_100_CYC;
  localparam [PER_W-1:0] PER_10_LEN = PERIOD_10_CYC;
  localparam [PER_W-1:0] PER_ONE = {{(PER_W-1){1'b0}}, 1'b1};
  localparam [PER_W-1:0] PER_ZERO = {PER_W{1'b0}};
  localparam [7:0] RST_CTRL4 = `SGC_RST_CTRL4_LOW;
  localparam [7:0] RST_RATE_LO = `SGC_RST_RATE_LO;
  localparam [7:0] RST_MISC = `SGC_RST_MISC;
  localparam [7:0] MISC_RW_MASK = `SGC_MISC_RW_MASK;
  localparam SEL_CTRL4 = 0;
  localparam SEL_RATE_LO = 1;
  localparam SEL_TEST_A = 2;
  localparam SEL_TEST_B = 3;
  localparam SEL_TEST_C = 4;
  localparam SEL_MISC = 5;
  localparam NUM_SEL = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchroniser and reset capture
  // The strap pin is asynchronous, so only the second flop is ever read
  reg strap_s1_ff;
  reg strap_s2_ff;
  reg rst_d_ff;
  wire strap_load;

  always @(posedge ref_clk_in) begin
    strap_s1_ff <= speed_strap_pin_in;
    strap_s2_ff <= strap_s1_ff;
  end

  always @(posedge ref_clk_in) begin
    rst_d_ff <= reset_in;
  end

  // Strap is taken in the cycle after reset is released, once the synchroniser holds a clean level
  assign strap_load = rst_d_ff & ~reset_in; // R2

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, one select line per implemented offset
  reg [NUM_SEL-1:0] sel_vec;
  always @* begin
    sel_vec = {NUM_SEL{1'b0}};
    case (reg_addr_in)
      `SGC_OFF_CTRL4: begin
        sel_vec[SEL_CTRL4] = 1'b1;
      end
      `SGC_OFF_RATE_LO: begin
        sel_vec[SEL_RATE_LO] = 1'b1;
      end
      `SGC_OFF_TEST_A: begin
        sel_vec[SEL_TEST_A] = 1'b1; // R7
      end
      `SGC_OFF_TEST_B: begin
        sel_vec[SEL_TEST_B] = 1'b1; // R7
      end
      `SGC_OFF_TEST_C: begin
        sel_vec[SEL_TEST_C] = 1'b1; // R7
      end
      `SGC_OFF_MISC: begin
        sel_vec[SEL_MISC] = 1'b1;
      end
      default: begin
        sel_vec = {NUM_SEL{1'b0}};
      end
    endcase
  end

  // Only writable offsets get a strobe; test offsets and holes swallow writes
  wire wr_ctrl4;
  wire wr_rate;
  wire wr_misc;
  assign wr_ctrl4 = reg_wr_in & sel_vec[SEL_CTRL4];
  assign wr_rate = reg_wr_in & sel_vec[SEL_RATE_LO];
  assign wr_misc = reg_wr_in & sel_vec[SEL_MISC];

  ////////////////////////////////////////////////////////////////////////////
  // Offset 0x06 upper bits, plain storage for the neighbouring interface controls
  reg [2:0] ctrl4_top_ff;
  reg [2:0] nxt_ctrl4_top;
  always @* begin
    nxt_ctrl4_top = ctrl4_top_ff;
    if (wr_ctrl4) begin
      nxt_ctrl4_top = reg_wdata_in[7:5];
    end
  end
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      ctrl4_top_ff <= RST_CTRL4[7:5];
    end else begin
      ctrl4_top_ff <= nxt_ctrl4_top;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed bit, the strap wins over a write in the first cycle after release
  reg speed_ff;
  reg nxt_speed;
  always @* begin
    nxt_speed = speed_ff;
    if (wr_ctrl4) begin
      nxt_speed = reg_wdata_in[`SGC_BIT_SPEED]; // R1
    end
    if (strap_load) begin
      nxt_speed = strap_s2_ff; // R2
    end
  end
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      speed_ff <= RST_CTRL4[`SGC_BIT_SPEED];
    end else begin
      speed_ff <= nxt_speed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Null identifier replacement enable
  reg nullvid_ff;
  reg nxt_nullvid;
  always @* begin
    nxt_nullvid = nullvid_ff;
    if (wr_ctrl4) begin
      nxt_nullvid = reg_wdata_in[`SGC_BIT_NULLVID]; // R3
    end
  end
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      nullvid_ff <= RST_CTRL4[`SGC_BIT_NULLVID];
    end else begin
      nullvid_ff <= nxt_nullvid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storm threshold upper bits
  reg [2:0] rate_hi_ff;
  reg [2:0] nxt_rate_hi;
  always @* begin
    nxt_rate_hi = rate_hi_ff;
    if (wr_ctrl4) begin
      nxt_rate_hi = reg_wdata_in[`SGC_RATE_HI_MSB:0]; // R4
    end
  end
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      rate_hi_ff <= RST_CTRL4[`SGC_RATE_HI_MSB:0]; // R6
    end else begin
      rate_hi_ff <= nxt_rate_hi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storm threshold low byte
  reg [7:0] rate_lo_ff;
  reg [7:0] nxt_rate_lo;
  always @* begin
    nxt_rate_lo = rate_lo_ff;
    if (wr_rate) begin
      nxt_rate_lo = reg_wdata_in; // R4
    end
  end
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      rate_lo_ff <= RST_RATE_LO; // R6
    end else begin
      rate_lo_ff <= nxt_rate_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset 0x0b, reserved top bit is masked off so it can never be stored
  reg [6:0] misc_ff;
  reg [6:0] nxt_misc;
  wire [7:0] misc_wdata;
  assign misc_wdata = reg_wdata_in & MISC_RW_MASK; // R8
  always @* begin
    nxt_misc = misc_ff;
    if (wr_misc) begin
      nxt_misc = misc_wdata[6:0];
    end
  end
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      misc_ff <= RST_MISC[6:0];
    end else begin
      misc_ff <= nxt_misc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read views of the mixed registers
  reg [7:0] ctrl4_view;
  reg [7:0] misc_view;
  always @* begin
    ctrl4_view = 8'h00;
    ctrl4_view[7:5] = ctrl4_top_ff;
    ctrl4_view[`SGC_BIT_SPEED] = speed_ff; // R1
    ctrl4_view[`SGC_BIT_NULLVID] = nullvid_ff; // R3
    ctrl4_view[`SGC_RATE_HI_MSB:0] = rate_hi_ff; // R4
  end
  always @* begin
    misc_view = 8'h00;
    misc_view[6:0] = misc_ff;
    misc_view[`SGC_MISC_RSVD_BIT] = 1'b0; // R8
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, and-or mux so an unmapped offset reads zero
  always @* begin
    reg_rdata_out = 8'h00;
    if (sel_vec[SEL_CTRL4]) begin
      reg_rdata_out = reg_rdata_out | ctrl4_view;
    end
    if (sel_vec[SEL_RATE_LO]) begin
      reg_rdata_out = reg_rdata_out | rate_lo_ff;
    end
    if (sel_vec[SEL_TEST_A]) begin
      reg_rdata_out = reg_rdata_out | `SGC_RST_TEST_A; // R7
    end
    if (sel_vec[SEL_TEST_B]) begin
      reg_rdata_out = reg_rdata_out | `SGC_RST_TEST_B; // R7
    end
    if (sel_vec[SEL_TEST_C]) begin
      reg_rdata_out = reg_rdata_out | `SGC_RST_TEST_C; // R7
    end
    if (sel_vec[SEL_MISC]) begin
      reg_rdata_out = reg_rdata_out | misc_view; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs
  assign port5_switch_mac_interface_10m_out = speed_ff; // R1
  assign null_vid_replace_out = nullvid_ff; // R3
  assign storm_threshold_out = {rate_hi_ff, rate_lo_ff}; // R4

  ////////////////////////////////////////////////////////////////////////////
  // Measurement period timer, length follows the selected speed
  // A speed change takes effect at the next compare, so one period may run long or short
  reg [PER_W-1:0] period_cnt_ff;
  reg period_tick_ff;
  reg [PER_W-1:0] nxt_period_cnt;
  reg nxt_period_tick;
  wire [PER_W-1:0] period_len;
  wire period_end;
  assign period_len = speed_ff ? PER_10_LEN : PER_100_LEN; // R5
  assign period_end = (period_cnt_ff >= period_len - PER_ONE);
  always @* begin
    nxt_period_cnt = period_cnt_ff + PER_ONE;
    nxt_period_tick = 1'b0;
    if (period_end) begin
      nxt_period_cnt = PER_ZERO; // R5
      nxt_period_tick = 1'b1;
    end
  end
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      period_cnt_ff <= PER_ZERO;
      period_tick_ff <= 1'b0;
    end else begin
      period_cnt_ff <= nxt_period_cnt;
      period_tick_ff <= nxt_period_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port storm counters
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
      sgc_storm_port #(
        .CNT_W(CNT_W)
      ) u_port (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .period_tick_in(period_tick_ff),
        .threshold_in(storm_threshold_out),
        .bcast_sof_in(bcast_sof_in[gi]),
        .bcast_block_in(bcast_block_in[gi]),
        .drop_out(bcast_drop_out[gi])
      );
    end
  endgenerate

endmodule

// >>> verilog/sgc_regs.vh
// Register offsets, field positions, reset values and timing for the global control slice
`ifndef SGC_REGS_VH
`define SGC_REGS_VH
`define SGC_OFF_CTRL4 8'h06
`define SGC_OFF_RATE_LO 8'h07
`define SGC_OFF_TEST_A 8'h08
`define SGC_OFF_TEST_B 8'h09
`define SGC_OFF_TEST_C 8'h0a
`define SGC_OFF_MISC 8'h0b
`define SGC_BIT_SPEED 4
`define SGC_BIT_NULLVID 3
`define SGC_RATE_HI_MSB 2
`define SGC_MISC_RSVD_BIT 7
`define SGC_RST_CTRL4_LOW 8'h00
`define SGC_RST_RATE_LO 8'h4a
`define SGC_RST_TEST_A 8'h00
`define SGC_RST_TEST_B 8'h4c
`define SGC_RST_TEST_C 8'h00
`define SGC_RST_MISC 8'h00
`define SGC_MISC_RW_MASK 8'h7f
`define SGC_PERIOD_100_MS 50
`define SGC_PERIOD_10_MS 500
`define SGC_CLK_HZ 40000000
`define SGC_BLOCK_BYTES 64
`endif

// >>> verilog/sgc_storm_port.v
// Per-port broadcast storm block counter
`timescale 1ns/1ps
module sgc_storm_port #(
  parameter CNT_W = 11
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // Period and threshold
  input wire period_tick_in,
  input wire [CNT_W-1:0] threshold_in,
  // Broadcast traffic
  input wire bcast_sof_in,
  input wire bcast_block_in,
  output wire drop_out
);
  reg [CNT_W-1:0] count_ff;
  reg drop_ff;
  wire at_limit;
  assign at_limit = (count_ff >= threshold_in);
  assign drop_out = drop_ff;
  always @(posedge ref_clk_in) begin
    if (reset_in | period_tick_in) begin
      count_ff <= {CNT_W{1'b0}}; // R9
      drop_ff <= 1'b0;
    end else begin
      // Drop decision is latched at frame start and held until the next frame start, though a period tick clears it mid-frame
      if (bcast_sof_in)
        drop_ff <= at_limit; // R9
      if (bcast_block_in && !at_limit)
        count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1}; // R4
    end
  end
endmodule
